// ===== src/dfo_top.sv
`timescale 1ns/1ps
module dfo_top
  import dfo_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          clk_en,
  // configuration
  input  wire logic [1:0]                    variant,
  input  wire logic [dfo_pkg::NUM_CH-1:0]    input_in_use,
  input  wire logic [3*dfo_pkg::FREQ_W-1:0]  freq_min_hz,
  input  wire logic [3*dfo_pkg::FREQ_W-1:0]  freq_max_hz,
  // signal source per channel
  input  wire logic [3*dfo_pkg::FREQ_W-1:0]  src_freq_hz,
  input  wire logic [3*dfo_pkg::DUTY_W-1:0]  src_duty,
  input  wire logic [dfo_pkg::NUM_CH-1:0]    src_level,
  // output_channel_socket pins, channel 0 also on shared_io_socket
  output logic      [dfo_pkg::NUM_CH-1:0]    out_pin,
  output logic      [dfo_pkg::NUM_CH-1:0]    out_oe
);
  typedef struct packed {
    logic [NUM_CH-1:0] oe;
  } dfo_top_s;
  dfo_top_s st_reg, st_next;

  logic [NUM_CH-1:0] allowed;
  logic [NUM_CH-1:0] wave;
  dfo_mode_e         mode_w [NUM_CH];

  always_comb begin
    allowed = '0;
    case (variant)
      VARIANT_GEN2: allowed = 3'h7;
      VARIANT_A16:  allowed = 3'h1;
      default:      allowed = 3'h3;
    endcase
    st_next.oe = allowed & ~input_in_use;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [FREQ_W-1:0] fmin, fmax, fsel;
    logic [CNT_W-1:0]  per, hi;
    logic [CNT_W+DUTY_W-1:0] prod;
    assign fmin = freq_min_hz[i*FREQ_W +: FREQ_W];
    assign fmax = freq_max_hz[i*FREQ_W +: FREQ_W];

    always_comb begin
      if (!st_reg.oe[i]) begin
        mode_w[i] = DFO_OFF;
      end else if (fmin < fmax) begin
        mode_w[i] = DFO_FREQ;
      end else if (fmin == fmax) begin
        mode_w[i] = DFO_PWM;
      end else begin
        mode_w[i] = DFO_SWITCH;
      end
    end

    always_comb begin
      // clamp the requested frequency into the supported band
      fsel = (mode_w[i] == DFO_PWM) ? fmin : src_freq_hz[i*FREQ_W +: FREQ_W];
      if (fsel < FREQ_W'(FREQ_MIN_HZ)) begin
        fsel = FREQ_W'(FREQ_MIN_HZ);
      end else if (fsel > FREQ_W'(FREQ_MAX_HZ)) begin
        fsel = FREQ_W'(FREQ_MAX_HZ);
      end
      per  = CNT_W'(CLK_HZ / 32'(fsel));
      prod = per * src_duty[i*DUTY_W +: DUTY_W];
      // square wave is fixed at half duty; PWM duty is src_duty/256
      hi   = (mode_w[i] == DFO_PWM) ? prod[CNT_W+DUTY_W-1:DUTY_W] : (per >> 1);
    end

    dfo_chan u_chan (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .clk_en     (clk_en),
      .mode       (mode_w[i]),
      .period_cyc (per),
      .high_cyc   (hi),
      .level      (src_level[i]),
      .wave       (wave[i])
    );

    AST_OE_GATE: assert property (@(posedge clk) disable iff (sys_rst)
      !st_reg.oe[i] |-> !out_pin[i])
      else $error("disabled channel drives high");
    AST_SWITCH_LVL: assert property (@(posedge clk) disable iff (sys_rst)
      (clk_en && mode_w[i] == DFO_SWITCH) ##1 (clk_en && mode_w[i] == DFO_SWITCH)
      |-> out_pin[i] == $past(src_level[i]))
      else $error("switch level does not follow source");

    // a mode change may cut a high phase short, so only a steady mode counts
    AST_FREQ_SLOW: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(wave[i]) && mode_w[i] == DFO_FREQ
      |-> ##1 (wave[i] || mode_w[i] != DFO_FREQ))
      else $error("square wave faster than 100 kHz");

    AST_PWM_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      (mode_w[i] == DFO_PWM && src_duty[i*DUTY_W +: DUTY_W] == '0 && clk_en) [*2]
      |-> !wave[i])
      else $error("zero duty gives high output");

    COV_FREQ: cover property (@(posedge clk) mode_w[i] == DFO_FREQ && $rose(wave[i]));
    COV_PWM: cover property (@(posedge clk) mode_w[i] == DFO_PWM && $fell(wave[i]));
    COV_SW: cover property (@(posedge clk) mode_w[i] == DFO_SWITCH && wave[i]);

    // the clamp must keep every period inside the supported band
    AST_PER_BAND: assert property (@(posedge clk) disable iff (sys_rst)
      (mode_w[i] == DFO_FREQ || mode_w[i] == DFO_PWM)
      |-> per >= PER_MIN_CYC && per <= PER_MAX_CYC)
      else $error("period outside the supported band");

    AST_SRC_PER: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_FREQ && src_freq_hz[i*FREQ_W +: FREQ_W] >= FREQ_MIN_HZ
      && src_freq_hz[i*FREQ_W +: FREQ_W] <= FREQ_MAX_HZ
      |-> per == CLK_HZ / src_freq_hz[i*FREQ_W +: FREQ_W])
      else $error("square period does not match source frequency");

    // out-of-band requests run at the nearest supported frequency
    AST_CLAMP_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_FREQ && src_freq_hz[i*FREQ_W +: FREQ_W] < FREQ_MIN_HZ
      |-> per == PER_MAX_CYC)
      else $error("low source not clamped to slowest period");

    AST_CLAMP_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_FREQ && src_freq_hz[i*FREQ_W +: FREQ_W] > FREQ_MAX_HZ
      |-> per == PER_MIN_CYC)
      else $error("high source not clamped to fastest period");

    AST_HI_POS: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_FREQ
      |-> hi != '0)
      else $error("square wave has no high phase");

    // pwm runs at the minimum setting, whatever the source frequency
    AST_PWM_FMIN: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_PWM && fmin >= FREQ_MIN_HZ && fmin <= FREQ_MAX_HZ
      |-> per == CLK_HZ / fmin)
      else $error("pwm period does not follow minimum setting");

    AST_HI_LE_PER: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_PWM
      |-> hi <= per)
      else $error("pwm high time longer than period");

    AST_PWM_HI_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      mode_w[i] == DFO_PWM && src_duty[i*DUTY_W +: DUTY_W] == '0
      |-> hi == '0)
      else $error("zero duty gives nonzero high time");

    AST_OE_OFF_MODE: assert property (@(posedge clk) disable iff (sys_rst)
      !st_reg.oe[i]
      |-> mode_w[i] == DFO_OFF)
      else $error("disabled channel left in an active mode");

    AST_INUSE_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      clk_en && input_in_use[i]
      |=> !out_oe[i] && !out_pin[i])
      else $error("channel in input use still drives");

    // a low enable must hold the pins exactly where they were
    AST_FREEZE: assert property (@(posedge clk) disable iff (sys_rst)
      !clk_en && !sys_rst
      |=> $stable(out_pin[i]) && $stable(out_oe[i]))
      else $error("outputs moved while the clock enable was low");
  end

  assign out_pin = wave & st_reg.oe;
  assign out_oe  = st_reg.oe;

  AST_A16_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    variant == VARIANT_A16 && clk_en |=> st_reg.oe[2:1] == 2'h0)
    else $error("sixteen-input variant enabled extra channel");
  AST_GEN2_ALL: assert property (@(posedge clk) disable iff (sys_rst)
    variant == VARIANT_GEN2 && input_in_use == '0 && clk_en
    |=> st_reg.oe == 3'h7)
    else $error("gen2 channels not all enabled");

  AST_GEN2_INUSE: assert property (@(posedge clk) disable iff (sys_rst)
    variant == VARIANT_GEN2 && clk_en
    |=> out_oe == ~$past(input_in_use))
    else $error("gen2 enables do not mirror unused inputs");

  AST_A16_INUSE: assert property (@(posedge clk) disable iff (sys_rst)
    variant == VARIANT_A16 && clk_en
    |=> out_oe[0] == !$past(input_in_use[0]))
    else $error("sixteen-input first channel enable wrong");

  AST_A16_PINS: assert property (@(posedge clk) disable iff (sys_rst)
    variant == VARIANT_A16 && clk_en
    |=> out_pin[2:1] == 2'h0)
    else $error("sixteen-input variant drives extra pin");

  // the base variant has no third output at all
  AST_BASE_TWO: assert property (@(posedge clk) disable iff (sys_rst)
    variant == VARIANT_BASE && clk_en
    |=> !out_oe[2] && !out_pin[2])
    else $error("base variant drives third channel");

  // reset wins over a low clock enable
  AST_RST_QUIET: assert property (@(posedge clk)
    sys_rst
    |=> out_oe == '0 && out_pin == '0)
    else $error("outputs active after reset");

  COV_FREEZE: cover property (@(posedge clk) !clk_en && out_oe != '0);
endmodule : dfo_top

// ===== src/dfo_pkg.sv
package dfo_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned NUM_CH        = 3;
  localparam int unsigned FREQ_MIN_HZ   = 2;
  localparam int unsigned FREQ_MAX_HZ   = 100_000;
  localparam int unsigned FREQ_W        = 17;
  localparam int unsigned DUTY_W        = 8;
  localparam int unsigned CNT_W         = 26;
  // half period bounds in cycles: longest half at 2 Hz, shortest at 100 kHz
  localparam int unsigned HALF_MAX_CYC  = CLK_HZ / (2 * FREQ_MIN_HZ);
  localparam int unsigned HALF_MIN_CYC  = CLK_HZ / (2 * FREQ_MAX_HZ);
  localparam int unsigned PER_MAX_CYC   = CLK_HZ / FREQ_MIN_HZ;
  localparam int unsigned PER_MIN_CYC   = CLK_HZ / FREQ_MAX_HZ;
  localparam logic [1:0]  VARIANT_BASE  = 2'h0;
  localparam logic [1:0]  VARIANT_A16   = 2'h1;
  localparam logic [1:0]  VARIANT_GEN2  = 2'h2;
  localparam logic [2:0]  OUT_RST       = 3'h0;

  typedef enum logic [1:0] {
    DFO_OFF    = 2'b00,
    DFO_FREQ   = 2'b01,
    DFO_PWM    = 2'b11,
    DFO_SWITCH = 2'b10
  } dfo_mode_e;
endpackage : dfo_pkg

// ===== src/dfo_chan.sv
`timescale 1ns/1ps
module dfo_chan
  import dfo_pkg::*;
(
  // clock
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  // control
  input  wire dfo_pkg::dfo_mode_e       mode,
  input  wire logic [dfo_pkg::CNT_W-1:0] period_cyc,
  input  wire logic [dfo_pkg::CNT_W-1:0] high_cyc,
  input  wire logic                     level,
  // output
  output logic                          wave
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             wave;
  } dfo_chan_s;
  dfo_chan_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    case (mode)
      DFO_FREQ, DFO_PWM: begin
        // period is compared every cycle, so a new setting takes effect at once and can make a runt
        if (st_reg.cnt + CNT_W'(1) >= period_cyc) begin
          st_next.cnt = '0;
        end else begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
        st_next.wave = (st_next.cnt < high_cyc);
      end
      DFO_SWITCH: begin
        st_next.cnt  = '0;
        st_next.wave = level;
      end
      default: begin
        st_next.cnt  = '0;
        st_next.wave = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign wave = st_reg.wave;
endmodule : dfo_chan

// ===== bench/dfo_sink.sv
`timescale 1ns/1ps
module dfo_sink
  import dfo_pkg::*;
(
  // clock
  input  wire logic                    clk,
  // observed output pins
  input  wire logic [NUM_CH-1:0]       pin,
  // last measured period and high time, in clock cycles
  output logic      [NUM_CH-1:0][31:0] per_cyc,
  output logic      [NUM_CH-1:0][31:0] hi_cyc
);
  logic [NUM_CH-1:0]       pin_reg;
  logic [NUM_CH-1:0][31:0] cnt_reg;
  // counts restart at each rising edge, so a stale partial period shows only once
  always_ff @(posedge clk) begin
    pin_reg <= pin;
    for (int i = 0; i < NUM_CH; i++) begin
      cnt_reg[i] <= cnt_reg[i] + 32'h1;
      if (pin[i] && !pin_reg[i]) begin
        per_cyc[i] <= cnt_reg[i];
        cnt_reg[i] <= 32'h1;
      end
      if (!pin[i] && pin_reg[i]) hi_cyc[i] <= cnt_reg[i];
    end
  end
endmodule : dfo_sink

// ===== bench/test_digital_frequency_output.sv
`timescale 1ns/1ps
module test_digital_frequency_output;
  import dfo_pkg::*;
  logic                    clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic                    clk_en = 1'b1;
  logic [1:0]              variant = VARIANT_GEN2;
  logic [NUM_CH-1:0]       input_in_use = '0;
  logic [3*FREQ_W-1:0]     freq_min_hz = '0;
  logic [3*FREQ_W-1:0]     freq_max_hz = '0;
  logic [3*FREQ_W-1:0]     src_freq_hz = '0;
  logic [3*DUTY_W-1:0]     src_duty = '0;
  logic [NUM_CH-1:0]       src_level = '0;
  logic [NUM_CH-1:0]       out_pin, out_oe;
  logic [NUM_CH-1:0][31:0] per_cyc, hi_cyc;
  int                      mismatches = 0;
  int                      cmp_count = 0;
  always #5 clk = ~clk;
  dfo_top dfo_top_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .variant(variant),
    .input_in_use(input_in_use), .freq_min_hz(freq_min_hz), .freq_max_hz(freq_max_hz),
    .src_freq_hz(src_freq_hz), .src_duty(src_duty), .src_level(src_level),
    .out_pin(out_pin), .out_oe(out_oe));
  dfo_sink dfo_sink_inst (.clk(clk), .pin(out_pin), .per_cyc(per_cyc), .hi_cyc(hi_cyc));
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  task automatic set_ch(int i, int fmin, int fmax, int fsrc, int duty, logic lvl);
    freq_min_hz[i*FREQ_W +: FREQ_W] = fmin[FREQ_W-1:0];
    freq_max_hz[i*FREQ_W +: FREQ_W] = fmax[FREQ_W-1:0];
    src_freq_hz[i*FREQ_W +: FREQ_W] = fsrc[FREQ_W-1:0];
    src_duty[i*DUTY_W +: DUTY_W] = duty[DUTY_W-1:0];
    src_level[i] = lvl;
  endtask : set_ch
  // duty is in 1/256 steps, so a square wave passes 128
  task automatic check_wave(int i, int f, int duty);
    int per;
    per = CLK_HZ / f;
    check("period", per, per_cyc[i]);
    check("high time", per * duty / 256, hi_cyc[i]);
  endtask : check_wave
  task automatic t_square;
    set_ch(0, 2, 100000, 131071, 0, 1'b0);
    set_ch(1, 2, 100000, 50000, 0, 1'b0);
    cyc(7000);
    check_wave(0, 100000, 128);
    check_wave(1, 50000, 128);
  endtask : t_square
  task automatic t_pwm;
    set_ch(0, 50000, 50000, 1000, 64, 1'b0);
    set_ch(2, 100000, 100000, 7, 192, 1'b0);
    cyc(7000);
    check_wave(0, 50000, 64);
    check_wave(2, 100000, 192);
  endtask : t_pwm
  // below-band source and zero duty reach the clamp and zero-duty paths
  task automatic t_edges;
    set_ch(0, 2, 100000, 1, 0, 1'b0);
    set_ch(2, 1000, 1000, 0, 0, 1'b0);
    cyc(20);
    check("zero duty pin", 32'h0, 32'(out_pin[2]));
  endtask : t_edges
  task automatic t_switch;
    for (int i = 0; i < NUM_CH; i++) set_ch(i, 10, 5, 1000, 0, i != 1);
    cyc(2);
    check("switch pins", 3'b101, out_pin);
    check("enables", 3'b111, out_oe);
    src_level = 3'b010;
    cyc(2);
    check("switch pins", 3'b010, out_pin);
  endtask : t_switch
  task automatic t_variant;
    src_level = 3'b111;
    variant = VARIANT_A16;
    cyc(2);
    check("enables", 3'b001, out_oe);
    check("pins", 3'b001, out_pin);
    variant = VARIANT_BASE;
    cyc(2);
    check("enables", 3'b011, out_oe);
    variant = VARIANT_GEN2;
    input_in_use = 3'b010;
    cyc(2);
    check("enables", 3'b101, out_oe);
    check("pins", 3'b101, out_pin);
  endtask : t_variant
  // freeze with the enable low, then a reset in mid-run and recovery
  task automatic t_freeze_reset;
    clk_en = 1'b0;
    src_level = 3'b000;
    input_in_use = 3'b000;
    cyc(3);
    check("frozen pins", 3'b101, out_pin);
    check("frozen enables", 3'b101, out_oe);
    clk_en = 1'b1;
    cyc(2);
    check("pins", 3'b000, out_pin);
    check("enables", 3'b111, out_oe);
    src_level = 3'b111;
    sys_rst = 1'b1;
    cyc(2);
    check("reset enables", 3'b000, out_oe);
    check("reset pins", 3'b000, out_pin);
    sys_rst = 1'b0;
    cyc(1);
    check("enables after reset", 3'b111, out_oe);
    check("pins after reset", 3'b000, out_pin);
    cyc(1);
    check("pins after reset", 3'b111, out_pin);
  endtask : t_freeze_reset
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // the tests need about 14000 cycles; allow twice that
  initial begin
    #300000;
    mismatches++;
    final_report();
  end
  initial begin
    cyc(12);
    sys_rst = 1'b0;
    t_square();
    t_pwm();
    t_edges();
    t_switch();
    t_variant();
    t_freeze_reset();
    final_report();
  end
endmodule : test_digital_frequency_output
